//--- hw/event_interrupt_capture.sv
// sixteen channel event capture with sense, mask, event latch and apb registers
`include "event_interrupt_capture_consts.svh"

module event_interrupt_capture (
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    input  wire logic [15:0] chan_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             irq_o
);

    // ************************************************************
    // bus request
    // ************************************************************
    event_interrupt_capture_pkg::apb_req_s req;
    event_interrupt_capture_pkg::setting_s setting;
    event_interrupt_capture_pkg::field_t   sync_a;
    event_interrupt_capture_pkg::field_t   sync_b;
    event_interrupt_capture_pkg::field_t   event_latch;
    event_interrupt_capture_pkg::field_t   strobe;
    event_interrupt_capture_pkg::field_t   ev_clear;
    event_interrupt_capture_pkg::field_t   strobe_prev;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic       setup;
    logic       wr_en;
    logic       rd_en;
    logic       mapped;
    logic       any_pending;
    logic       lost;
    logic [31:0] next_rdata;

    assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
                   paddr: paddr_i, pwdata: pwdata_i};

    // one wait state: setup cycle, then access answered from registers
    assign setup = req.psel && req.penable && !pready_o;
    assign wr_en = setup && req.pwrite && mapped;
    assign rd_en = setup && !req.pwrite && mapped;

    always_comb begin
        mapped = 1'b1;
        unique case (req.paddr)
            `EIC_OFF_INPUT, `EIC_OFF_EVENT, `EIC_OFF_MASK, `EIC_OFF_SENSE,
            `EIC_OFF_COMBINED, `EIC_OFF_IRQ_STAT, `EIC_OFF_IRQ_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= setup;
            pslverr_o <= setup && !mapped;
        end
    end

    // ************************************************************
    // input synchroniser
    // ************************************************************
    // first stage feeds only the second; level departures are judged on sync_b
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            sync_a <= `EIC_RST_FIELD;
            sync_b <= `EIC_RST_FIELD;
        end else begin
            sync_a <= chan_i;
            sync_b <= sync_a;
        end
    end

    // ************************************************************
    // settings
    // ************************************************************
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            setting.sense <= `EIC_RST_FIELD;
            setting.mask  <= `EIC_RST_FIELD;
        end else if (wr_en && req.paddr == `EIC_OFF_MASK) begin
            setting.mask <= req.pwdata[15:0];
        end else if (wr_en && req.paddr == `EIC_OFF_SENSE) begin
            setting.sense <= req.pwdata[15:0];
        end else if (wr_en && req.paddr == `EIC_OFF_COMBINED) begin
            setting.sense <= req.pwdata[15:0];
            setting.mask  <= req.pwdata[31:16];
        end
    end

    // ************************************************************
    // event latch
    // ************************************************************
    // reading the latch clears exactly the bits returned; a strobe in that
    // same cycle wins so no event is dropped
    assign ev_clear = (rd_en && req.paddr == `EIC_OFF_EVENT) ? event_latch : `EIC_RST_FIELD;

    genvar ch;
    generate
        for (ch = 0; ch < `EIC_CHANNELS; ch++) begin : g_chan
            assign strobe[ch] = sync_b[ch] ^ setting.sense[ch];
            always_ff @(posedge clock_i) begin
                if (!reset_n_i) begin
                    event_latch[ch] <= 1'b0;
                end else if (strobe[ch] && !(event_latch[ch] && !ev_clear[ch])) begin
                    event_latch[ch] <= 1'b1;
                end else if (ev_clear[ch]) begin
                    event_latch[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    // ************************************************************
    // interrupt status
    // ************************************************************
    // a level departure holds the strobe, so loss is judged on a fresh
    // departure only; a held level would otherwise flag loss every cycle
    assign any_pending = |(event_latch & setting.mask);
    assign lost        = |(strobe & ~strobe_prev & event_latch & ~ev_clear & setting.mask);

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            strobe_prev <= `EIC_RST_FIELD;
        end else begin
            strobe_prev <= strobe;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            irq_stat <= `EIC_RST_IRQ;
        end else begin
            irq_stat[`EIC_IRQ_EVENT_BIT] <= any_pending ||
                (irq_stat[`EIC_IRQ_EVENT_BIT] &&
                 !(wr_en && req.paddr == `EIC_OFF_IRQ_STAT &&
                   req.pwdata[`EIC_IRQ_EVENT_BIT]));
            irq_stat[`EIC_IRQ_OVER_BIT] <= lost ||
                (irq_stat[`EIC_IRQ_OVER_BIT] &&
                 !(wr_en && req.paddr == `EIC_OFF_IRQ_STAT &&
                   req.pwdata[`EIC_IRQ_OVER_BIT]));
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            irq_mask <= `EIC_RST_IRQ;
        end else if (wr_en && req.paddr == `EIC_OFF_IRQ_MASK) begin
            irq_mask <= req.pwdata[1:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat & irq_mask);
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    always_comb begin
        next_rdata = `EIC_ZERO_WORD;
        unique case (req.paddr)
            `EIC_OFF_INPUT:    next_rdata[15:0] = sync_b;
            `EIC_OFF_EVENT:    next_rdata[15:0] = event_latch;
            `EIC_OFF_MASK:     next_rdata[15:0] = setting.mask;
            `EIC_OFF_SENSE:    next_rdata[15:0] = setting.sense;
            `EIC_OFF_COMBINED: next_rdata = {setting.mask, setting.sense};
            `EIC_OFF_IRQ_STAT: next_rdata[1:0] = irq_stat;
            `EIC_OFF_IRQ_MASK: next_rdata[1:0] = irq_mask;
            default:           next_rdata = `EIC_ZERO_WORD;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            prdata_o <= `EIC_ZERO_WORD;
        end else if (setup && !req.pwrite) begin
            prdata_o <= next_rdata;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_departure(int c);
        strobe[c] && !event_latch[c];
    endsequence

    chk_strobe_sets_latch: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        s_departure(0) |=> event_latch[0])
        else $error("departure did not latch event");
    chk_latch_holds_bit: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        event_latch[3] && !ev_clear[3] |=> event_latch[3])
        else $error("event lost without read");
    chk_mask_gates_irq: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (setting.mask & event_latch) == 16'h0000 && !irq_stat[0] && !irq_stat[1] |=> !irq_o)
        else $error("interrupt without masked event");
    chk_irq_follows_event: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        any_pending && irq_mask[0] |=> (irq_mask[0] |-> ##1 irq_o))
        else $error("interrupt missing after event");
    chk_mask_write: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wr_en && req.paddr == `EIC_OFF_MASK |=> setting.mask == $past(req.pwdata[15:0]))
        else $error("mask field not written");
    chk_combined_write: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wr_en && req.paddr == `EIC_OFF_COMBINED |=>
        setting.sense == $past(req.pwdata[15:0]) && setting.mask == $past(req.pwdata[31:16]))
        else $error("combined write wrong");
    chk_sense_write: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wr_en && req.paddr == `EIC_OFF_SENSE |=> setting.sense == $past(req.pwdata[15:0]))
        else $error("sense field not written");
    chk_input_read: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        rd_en && req.paddr == `EIC_OFF_INPUT |=> prdata_o[15:0] == $past(sync_b))
        else $error("input port read wrong");
    chk_readback: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        rd_en && req.paddr == `EIC_OFF_MASK |=> prdata_o[15:0] == $past(setting.mask))
        else $error("mask readback wrong");
    chk_sync_delay: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        1'b1 ##2 1'b1 |-> sync_b == $past(chan_i, 2))
        else $error("sync path not two stages");
    chk_event_read: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        rd_en && req.paddr == `EIC_OFF_EVENT |=> prdata_o[15:0] == $past(event_latch))
        else $error("event read wrong");

    // ************************************************************
    // bus handshake checks
    // ************************************************************
    // one wait state exactly: the answer is a single-cycle pulse
    chk_pready_pulse: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    chk_pready_after_setup: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        setup |=> pready_o)
        else $error("ready missing after access");
    chk_pready_only_setup: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !setup |=> !pready_o)
        else $error("ready without access");
    chk_idle_no_ready: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !req.psel |=> !pready_o)
        else $error("ready while idle");
    chk_slverr_unmapped: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        setup && !mapped |=> pslverr_o)
        else $error("unmapped access not refused");
    chk_slverr_mapped: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        setup && mapped |=> !pslverr_o)
        else $error("mapped access refused");
    chk_slverr_with_ready: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        pslverr_o |-> pready_o)
        else $error("error without ready");
    chk_unmapped_rdata: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        setup && !mapped && !req.pwrite |=> prdata_o == `EIC_ZERO_WORD)
        else $error("unmapped read not zero");
    chk_rdata_holds: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !(setup && !req.pwrite) |=> $stable(prdata_o))
        else $error("read data moved without read");
    chk_write_no_rdata: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wr_en |=> $stable(prdata_o))
        else $error("write changed read data");

    // ************************************************************
    // register checks
    // ************************************************************
    chk_sense_readback: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        rd_en && req.paddr == `EIC_OFF_SENSE |=> prdata_o[15:0] == $past(setting.sense))
        else $error("sense readback wrong");
    chk_combined_read: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        rd_en && req.paddr == `EIC_OFF_COMBINED |=>
        prdata_o == {$past(setting.mask), $past(setting.sense)})
        else $error("combined readback wrong");
    chk_input_read_high: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        rd_en && req.paddr == `EIC_OFF_INPUT |=> prdata_o[31:16] == `EIC_RST_FIELD)
        else $error("input read upper half not zero");
    chk_stat_read: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        rd_en && req.paddr == `EIC_OFF_IRQ_STAT |=> prdata_o[1:0] == $past(irq_stat))
        else $error("status read wrong");
    chk_irqmask_read: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        rd_en && req.paddr == `EIC_OFF_IRQ_MASK |=> prdata_o[1:0] == $past(irq_mask))
        else $error("interrupt mask read wrong");
    chk_irqmask_write: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wr_en && req.paddr == `EIC_OFF_IRQ_MASK |=> irq_mask == $past(req.pwdata[1:0]))
        else $error("interrupt mask not written");
    chk_setting_hold: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !wr_en |=> $stable(setting))
        else $error("settings moved without write");
    chk_irqmask_hold: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !wr_en |=> $stable(irq_mask))
        else $error("interrupt mask moved without write");

    // ************************************************************
    // event and interrupt checks
    // ************************************************************
    chk_sync_first: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        1'b1 |=> sync_a == $past(chan_i))
        else $error("first sync stage wrong");
    chk_no_spurious: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !strobe[5] && !event_latch[5] |=> !event_latch[5])
        else $error("event latched without departure");
    chk_read_clears: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        rd_en && req.paddr == `EIC_OFF_EVENT && !strobe[2] |=> !event_latch[2])
        else $error("read did not clear event");
    chk_set_wins_read: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        strobe[1] && rd_en && req.paddr == `EIC_OFF_EVENT |=> event_latch[1])
        else $error("event dropped on read");
    chk_pending_sets_stat: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        any_pending |=> irq_stat[`EIC_IRQ_EVENT_BIT])
        else $error("pending event not flagged");
    chk_lost_sets_stat: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        lost |=> irq_stat[`EIC_IRQ_OVER_BIT])
        else $error("lost event not flagged");
    chk_lost_needs_latch: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        lost |-> (event_latch & setting.mask) != `EIC_RST_FIELD)
        else $error("loss without latched event");
    chk_stat_sticky: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        irq_stat[`EIC_IRQ_EVENT_BIT] && !wr_en |=> irq_stat[`EIC_IRQ_EVENT_BIT])
        else $error("status dropped without clear");
    chk_stat_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wr_en && req.paddr == `EIC_OFF_IRQ_STAT && req.pwdata[`EIC_IRQ_EVENT_BIT] &&
        !any_pending |=> !irq_stat[`EIC_IRQ_EVENT_BIT])
        else $error("status not cleared by write");
    chk_masked_quiet: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        setting.mask == `EIC_RST_FIELD |-> !any_pending)
        else $error("masked channel made pending");
    chk_irq_needs_mask: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        irq_mask == `EIC_RST_IRQ |=> !irq_o)
        else $error("interrupt with mask clear");
    chk_irq_from_stat: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        irq_stat[`EIC_IRQ_EVENT_BIT] && irq_mask[`EIC_IRQ_EVENT_BIT] |=> irq_o)
        else $error("interrupt missing for status");

endmodule

//--- hw/event_interrupt_capture_consts.svh
// register offsets, reset values and field constants for the event capture block
`ifndef EVENT_INTERRUPT_CAPTURE_CONSTS_SVH
`define EVENT_INTERRUPT_CAPTURE_CONSTS_SVH
`define EIC_CHANNELS      16
`define EIC_OFF_INPUT     12'h000
`define EIC_OFF_EVENT     12'h004
`define EIC_OFF_MASK      12'h008
`define EIC_OFF_SENSE     12'h00C
`define EIC_OFF_COMBINED  12'h010
`define EIC_OFF_IRQ_STAT  12'h014
`define EIC_OFF_IRQ_MASK  12'h018
`define EIC_RST_FIELD     16'h0000
`define EIC_RST_IRQ       2'h0
`define EIC_IRQ_EVENT_BIT 0
`define EIC_IRQ_OVER_BIT  1
`define EIC_ZERO_WORD     32'h00000000
`endif

//--- hw/event_interrupt_capture_pkg.sv
// types shared by the event capture block
package event_interrupt_capture_pkg;
    typedef logic [15:0] field_t;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;
    typedef struct packed {
        logic [15:0] sense;
        logic [15:0] mask;
    } setting_s;
endpackage

//--- verification/host_model.sv
// apb host standing in for the mainframe control processor
module host_model (
    input  wire logic        clock_i,
    input  wire logic        pready_i,
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic      [11:0] paddr_o,
    output logic      [31:0] pwdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // transfer engine
    // ****************
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h00000000;
    end
    // request held until pready seen high; whole fields go as one word
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel_o <= 1'b1;
        pwrite_o <= wr;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clock_i);
        penable_o <= 1'b1;
        @(posedge clock_i);
        while (pready_i !== 1'b1) @(posedge clock_i);
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
endmodule

//--- verification/testbench.sv
// self-checking bench for the event capture block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [15:0] chan_i = 16'h0000;
    logic        psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    int          fails = 0;
    int          checks = 0;
    int          cycles = 0;
    always #10 clock_i = ~clock_i;
    event_interrupt_capture dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .chan_i(chan_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .irq_o(irq));
    host_model hst_u (.clock_i(clock_i), .pready_i(pready), .psel_o(psel),
        .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // note k = {compare data, expected slave error}
    task automatic bus(input logic wr, input logic [1:0] k, input logic [11:0] a,
                       input logic [31:0] d);
        exp_q.push_back({k, d});
        hst_u.xfer(wr, a, d);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, 2'b00, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        bus(1'b0, 2'b10, a, x);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // departure held well past the two-flop synchroniser, then idle again
    task automatic pulse(input logic [15:0] idle, input logic [15:0] v);
        chan_i <= v;
        tick(4);
        chan_i <= idle;
        tick(8);
    endtask
    task automatic chk_irq(input logic x);
        checks++;
        if (irq !== x) begin
            $display("[ERR] %0t irq %b exp %b", $time, irq, x);
            fails++;
        end
    endtask
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            $display("[ERR] %0t timeout", $time);
            fails++;
            end_sim();
        end
    end
    always @(posedge clock_i) begin
        if (pready === 1'b1) begin
            e = exp_q.pop_front();
            checks++;
            if (pslverr !== e[32] || (e[33] && prdata !== e[31:0])) begin
                $display("[ERR] %0t bus %h/%b exp %h/%b", $time, prdata, pslverr, e[31:0], e[32]);
                fails++;
            end
        end
    end
    // ****************
    // scenarios
    // ****************
    initial begin
        seed = 32'hFD7A18CC;
        tick(6);
        reset_n_i <= 1'b1;
        for (int i = 2; i < 7; i++) rd(12'(i * 4), 32'h00000000);
        bus(1'b0, 2'b11, 12'h01C, 32'h00000000);
        bus(1'b1, 2'b01, 12'h01C, 32'hFFFFFFFF);
        wr(12'h008, 32'h0000A5A5);
        rd(12'h008, 32'h0000A5A5);
        wr(12'h00C, 32'h00003C3C);
        rd(12'h00C, 32'h00003C3C);
        wr(12'h010, 32'h12345678);
        rd(12'h010, 32'h12345678);
        rd(12'h008, 32'h00001234);
        rd(12'h00C, 32'h00005678);
        wr(12'h010, 32'h00000000);
        $display("test settings done");
        repeat (4) begin
            seed = lfsr(seed);
            chan_i <= seed[15:0];
            tick(4);
            rd(12'h000, {16'h0000, seed[15:0]});
        end
        chan_i <= 16'h0000;
        tick(4);
        bus(1'b0, 2'b00, 12'h004, 32'h00000000);
        rd(12'h004, 32'h00000000);
        $display("test input port done");
        wr(12'h018, 32'h00000001);
        wr(12'h008, 32'h00000001);
        pulse(16'h0000, 16'h0003);
        tick(30);
        chk_irq(1'b1);
        rd(12'h014, 32'h00000001);
        rd(12'h004, 32'h00000003);
        wr(12'h014, 32'h00000001);
        tick(3);
        chk_irq(1'b0);
        pulse(16'h0000, 16'h0002);
        chk_irq(1'b0);
        rd(12'h004, 32'h00000002);
        $display("test interrupt done");
        pulse(16'h0000, 16'h0001);
        pulse(16'h0000, 16'h0001);
        rd(12'h014, 32'h00000003);
        wr(12'h018, 32'h00000000);
        tick(3);
        chk_irq(1'b0);
        wr(12'h018, 32'h00000001);
        tick(3);
        chk_irq(1'b1);
        rd(12'h004, 32'h00000001);
        wr(12'h014, 32'h00000003);
        tick(3);
        chk_irq(1'b0);
        $display("test hold-off done");
        wr(12'h008, 32'h00000000);
        pulse(16'hFFFF, 16'hFFFF);
        wr(12'h00C, 32'h0000FFFF);
        tick(4);
        bus(1'b0, 2'b00, 12'h004, 32'h00000000);
        rd(12'h004, 32'h00000000);
        pulse(16'hFFFF, 16'hFFEF);
        rd(12'h004, 32'h00000010);
        $display("test sense high done");
        end_sim();
    end
endmodule
